// *** src/supervision_timer.sv ***
/*
  supervision timer with prewarning, password access, init-done line
  and double reset detection, reached over apb.
  assumes nrst is the power-on reset only; sys_reset_out resets the rest
  of the chip but not this block.
*/
// Implementation choices: register access over APB and the address map.
`timescale 1ns/100ps
module supervision_timer
  import wdt_pkg::*;
#(
  parameter int DIV_F = DIV_FAST,
  parameter int DIV_S = DIV_SLOW
)
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             init_done_protect_bit,
  output logic             nmi,
  output logic             sys_reset_out,
  output logic             irq
);

  localparam int WW = $clog2(ACCESS_WINDOW_CYC);
  localparam int RW = $clog2(RESET_PULSE_CYC);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  tick_if tk ();

  presc_tick #(
    .DIV_F (DIV_F),
    .DIV_S (DIV_S)
  ) u_presc (
    .clk  (clk),
    .nrst (nrst),
    .tk   (tk.gen)
  );

  wd_state_t         state_q;
  wd_state_t         state_d;
  logic [15:0]       cnt_q;
  logic [15:0]       cnt_d;
  logic [15:0]       reload_q;
  logic [15:0]       reload_d;
  logic [7:0]        pw_q;
  logic [7:0]        pw_d;
  logic              init_q;
  logic              init_d;
  logic              dis_q;
  logic              dis_d;
  logic              slow_q;
  logic              slow_d;
  logic              open_q;
  logic              open_d;
  logic [WW-1:0]     win_q;
  logic [WW-1:0]     win_d;
  logic              rec_q;
  logic              rec_d;
  logic [RW-1:0]     rcnt_q;
  logic [RW-1:0]     rcnt_d;
  logic [IRQ_W-1:0]  ist_q;
  logic [IRQ_W-1:0]  ist_d;
  logic [IRQ_W-1:0]  imask_q;
  logic [IRQ_W-1:0]  imask_d;
  logic [31:0]       prdata_q;
  logic [31:0]       prdata_d;
  logic              pready_q;
  logic              pready_d;
  logic              pslverr_q;
  logic              pslverr_d;
  logic              nmi_q;
  logic              nmi_d;
  logic              srst_q;
  logic              srst_d;
  logic              irq_q;
  logic              irq_d;
  logic              load;
  logic              acc_err;
  logic              ovf_err;
  logic              wr_done;
  logic              mapped;
  logic              active;
  logic              counting;
  logic [IRQ_W-1:0]  ev;

  assign tk.slow_sel = slow_q;
  assign tk.restart  = load;

  // ----------------------------------------------------------------
  // apb slave, one wait state
  // ----------------------------------------------------------------
  always_comb
  begin
    mapped    = hit(paddr, ADDR_CTRL) | hit(paddr, ADDR_STATUS)
              | hit(paddr, ADDR_IRQ_STAT) | hit(paddr, ADDR_IRQ_MASK);
    wr_done   = psel & penable & pready_q & pwrite & mapped;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    prdata_d  = prdata_q;
    if (psel && penable && !pready_q)
    begin
      pready_d  = 1'b1;
      pslverr_d = ~mapped;
      prdata_d  = 32'h0000_0000;
      if (!pwrite)
      begin
        if (hit(paddr, ADDR_CTRL))
        begin
          prdata_d = {reload_q, pw_q, 4'h0, open_q, slow_q, dis_q, init_q};
        end
        else if (hit(paddr, ADDR_STATUS))
        begin
          prdata_d = {10'h000, rec_q, state_q, cnt_q};
        end
        else if (hit(paddr, ADDR_IRQ_STAT))
        begin
          prdata_d = {28'h0000000, ist_q};
        end
        else if (hit(paddr, ADDR_IRQ_MASK))
        begin
          prdata_d = {28'h0000000, imask_q};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // access sequence, counter and modes
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    reload_d = reload_q;
    pw_d     = pw_q;
    init_d   = init_q;
    dis_d    = dis_q;
    slow_d   = slow_q;
    open_d   = open_q;
    win_d    = win_q;
    rec_d    = rec_q;
    rcnt_d   = rcnt_q;
    load     = 1'b0;
    acc_err  = 1'b0;
    ovf_err  = 1'b0;
    active   = (state_q == ST_TIMEOUT) || (state_q == ST_NORMAL);
    // disable stops only normal-mode counting; access checks below still run
    counting = (state_q == ST_TIMEOUT) || (state_q == ST_PREWARN)
             || ((state_q == ST_NORMAL) && !dis_q);
    if (wr_done && hit(paddr, ADDR_CTRL) && active)
    begin
      if (!open_q)
      begin
        if (pwdata[CTRL_KEY_LSB +: 4] == PW_FIXED
            && pwdata[CTRL_PW_LSB +: 8] == pw_q)
        begin
          open_d = 1'b1;
          win_d  = '0;
        end
        else
        begin
          acc_err = 1'b1;
        end
      end
      else
      begin
        open_d = 1'b0;
        if (pwdata[CTRL_KEY_LSB +: 4] == GUARD_FIXED)
        begin
          init_d   = pwdata[CTRL_INIT_BIT];
          dis_d    = pwdata[CTRL_DIS_BIT];
          slow_d   = pwdata[CTRL_SLOW_BIT];
          pw_d     = pwdata[CTRL_PW_LSB +: 8];
          reload_d = pwdata[CTRL_REL_LSB +: 16];
          rec_d    = 1'b0;
          load     = 1'b1;
          // timeout mode ends once init is declared done
          if (state_q == ST_TIMEOUT && pwdata[CTRL_INIT_BIT])
          begin
            state_d = ST_NORMAL;
          end
          cnt_d = (state_d == ST_NORMAL) ? reload_d : FIXED_RELOAD;
        end
        else
        begin
          acc_err = 1'b1;
        end
      end
    end
    else if (open_q)
    begin
      win_d = win_q + WW'(1);
      if (win_q == WW'(ACCESS_WINDOW_CYC - 1))
      begin
        open_d  = 1'b0;
        acc_err = 1'b1;
      end
    end
    if (counting && tk.tick && !load)
    begin
      if (cnt_q == 16'hffff)
      begin
        if (state_q == ST_PREWARN)
        begin
          state_d = ST_RESET;
          rcnt_d  = '0;
          if (rec_q)
          begin
            state_d = ST_HOLD;
          end
          rec_d = 1'b1;
        end
        else
        begin
          ovf_err = 1'b1;
        end
      end
      else
      begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
    if (acc_err || ovf_err)
    begin
      state_d = ST_PREWARN;
      cnt_d   = FIXED_RELOAD;
      open_d  = 1'b0;
      load    = 1'b1;
    end
    if (state_q == ST_RESET)
    begin
      rcnt_d = rcnt_q + RW'(1);
      if (rcnt_q == RW'(RESET_PULSE_CYC - 1))
      begin
        // the chip restarts; the reset record, interrupt status and interrupt mask survive
        state_d  = ST_TIMEOUT;
        cnt_d    = FIXED_RELOAD;
        reload_d = RELOAD_RST;
        pw_d     = PW_RST;
        init_d   = 1'b0;
        dis_d    = 1'b0;
        slow_d   = 1'b0;
        load     = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt status, mask and outputs
  // ----------------------------------------------------------------
  always_comb
  begin
    ev               = '0;
    ev[IRQ_ACC_ERR]  = acc_err;
    ev[IRQ_OVF]      = ovf_err;
    ev[IRQ_INIT_CHG] = (init_d != init_q);
    ev[IRQ_PREWARN]  = (state_d == ST_PREWARN) && (state_q != ST_PREWARN);
    imask_d          = imask_q;
    ist_d            = ist_q;
    if (wr_done && hit(paddr, ADDR_IRQ_STAT))
    begin
      ist_d = ist_q & ~pwdata[IRQ_W-1:0];
    end
    if (wr_done && hit(paddr, ADDR_IRQ_MASK))
    begin
      imask_d = pwdata[IRQ_W-1:0];
    end
    // an event in the clearing cycle still lands
    ist_d  = ist_d | ev;
    irq_d  = |(ist_d & imask_d);
    nmi_d  = (state_d == ST_PREWARN);
    srst_d = (state_d == ST_RESET) || (state_d == ST_HOLD);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q   <= ST_TIMEOUT;
      cnt_q     <= FIXED_RELOAD;
      reload_q  <= RELOAD_RST;
      pw_q      <= PW_RST;
      init_q    <= 1'b0;
      dis_q     <= 1'b0;
      slow_q    <= 1'b0;
      open_q    <= 1'b0;
      win_q     <= '0;
      rec_q     <= 1'b0;
      rcnt_q    <= '0;
      ist_q     <= '0;
      imask_q   <= IRQ_MASK_RST;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      nmi_q     <= 1'b0;
      srst_q    <= 1'b0;
      irq_q     <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      reload_q  <= reload_d;
      pw_q      <= pw_d;
      init_q    <= init_d;
      dis_q     <= dis_d;
      slow_q    <= slow_d;
      open_q    <= open_d;
      win_q     <= win_d;
      rec_q     <= rec_d;
      rcnt_q    <= rcnt_d;
      ist_q     <= ist_d;
      imask_q   <= imask_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      nmi_q     <= nmi_d;
      srst_q    <= srst_d;
      irq_q     <= irq_d;
    end
  end

  assign prdata                = prdata_q;
  assign pready                = pready_q;
  assign pslverr               = pslverr_q;
  assign init_done_protect_bit = init_q;
  assign nmi                   = nmi_q;
  assign sys_reset_out         = srst_q;
  assign irq                   = irq_q;

endmodule

// *** src/wdt_pkg.sv ***
/*
  constants, register map and state codes of the supervision timer.
  assumes a 32-bit apb with byte addresses, one aligned word per register.
*/
package wdt_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;

  // ----------------------------------------------------------------
  // control word fields
  // ----------------------------------------------------------------
  localparam int CTRL_INIT_BIT  = 0;
  localparam int CTRL_DIS_BIT   = 1;
  localparam int CTRL_SLOW_BIT  = 2;
  localparam int CTRL_OPEN_BIT  = 3;
  localparam int CTRL_KEY_LSB   = 4;
  localparam int CTRL_PW_LSB    = 8;
  localparam int CTRL_REL_LSB   = 16;
  localparam logic [3:0] PW_FIXED    = 4'h5;
  localparam logic [3:0] GUARD_FIXED = 4'ha;

  // ----------------------------------------------------------------
  // reset values and fixed reload
  // ----------------------------------------------------------------
  localparam logic [15:0] FIXED_RELOAD = 16'hff00;
  localparam logic [15:0] RELOAD_RST   = 16'h0000;
  localparam logic [7:0]  PW_RST       = 8'h00;
  localparam logic [3:0]  IRQ_MASK_RST = 4'h0;

  // ----------------------------------------------------------------
  // interrupt status bits
  // ----------------------------------------------------------------
  localparam int IRQ_ACC_ERR  = 0;
  localparam int IRQ_OVF      = 1;
  localparam int IRQ_INIT_CHG = 2;
  localparam int IRQ_PREWARN  = 3;
  localparam int IRQ_W        = 4;

  // ----------------------------------------------------------------
  // timing counts in system clocks
  // ----------------------------------------------------------------
  localparam int DIV_FAST          = 256;
  localparam int DIV_SLOW          = 16384;
  localparam int ACCESS_WINDOW_CYC = 1024;
  localparam int RESET_PULSE_CYC   = 8;

  // ----------------------------------------------------------------
  // operating modes
  // ----------------------------------------------------------------
  typedef enum logic [4:0]
  {
    ST_TIMEOUT = 5'b00001,
    ST_NORMAL  = 5'b00010,
    ST_PREWARN = 5'b00100,
    ST_RESET   = 5'b01000,
    ST_HOLD    = 5'b10000
  } wd_state_t;

endpackage

// *** src/tick_if.sv ***
/*
  carrier between the timer core and its prescaler.
  assumes both ends sit on the same clock.
*/
`timescale 1ns/100ps
interface tick_if;
  logic slow_sel;
  logic restart;
  logic tick;
  modport gen (input slow_sel, input restart, output tick);
  modport use_end (output slow_sel, output restart, input tick);
endinterface

// *** src/presc_tick.sv ***
/*
  prescaler: one-cycle tick every div_fast or div_slow system clocks.
  assumes restart comes from logic on the same clock.
*/
`timescale 1ns/100ps
module presc_tick
  import wdt_pkg::*;
#(
  parameter int DIV_F = DIV_FAST,
  parameter int DIV_S = DIV_SLOW
)
(
  input  wire logic clk,
  input  wire logic nrst,
  tick_if.gen       tk
);

  localparam int CW = $clog2(DIV_S);

  logic [CW-1:0] div_q;
  logic [CW-1:0] div_d;
  logic          tick_q;
  logic          tick_d;
  logic [CW-1:0] limit;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  always_comb
  begin
    limit  = tk.slow_sel ? CW'(DIV_S - 1) : CW'(DIV_F - 1);
    tick_d = 1'b0;
    div_d  = div_q + CW'(1);
    // restart aligns a fresh full period with every counter load
    if (tk.restart)
    begin
      div_d = '0;
    end
    else if (div_q >= limit)
    begin
      div_d  = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  assign tk.tick = tick_q;

endmodule

// *** sim/supervision_timer_checker.sv ***
/*
  port checker for the supervision timer.
  assumes a bind onto supervision_timer and one clock domain.
*/
`timescale 1ns/100ps
module supervision_timer_checker
#(
  parameter int DIV_F = 256,
  parameter int DIV_S = 16384
)
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        init_done_protect_bit,
  input wire logic        nmi,
  input wire logic        sys_reset_out,
  input wire logic        irq
);
  logic [3:0] hi_d;
  logic [3:0] hi_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ------
  // reset high-time counter, saturating so hold never wraps
  // ------
  always_comb
  begin
    hi_d = !sys_reset_out ? 4'h0 : (hi_q == 4'hf ? hi_q : hi_q + 4'h1);
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hi_q <= 4'h0;
    end
    else
    begin
      hi_q <= hi_d;
    end
  end
  // ------
  // properties
  // ------
  sequence access_s;
    psel && penable && !pready;
  endsequence
  sequence warn_s;
    (nmi && !sys_reset_out) [*8];
  endsequence
  ready_wait_a: assert property ($rose(psel && penable) |-> !pready ##1 pready)
    else $error("pready not one cycle after penable");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  decode_err_a: assert property (access_s |=> pslverr == $past(paddr[7:4] != 4'h0))
    else $error("pslverr does not follow address decode");
  nmi_first_a: assert property ($rose(nmi) |-> warn_s)
    else $error("reset without prewarning period");
  reset_follows_a: assert property ($fell(nmi) |-> sys_reset_out)
    else $error("prewarning ended without reset");
  reset_cause_a: assert property ($rose(sys_reset_out) |-> $past(nmi))
    else $error("reset not preceded by nmi");
  pulse_len_a: assert property ($rose(sys_reset_out) |-> sys_reset_out [*8])
    else $error("reset pulse too short");
  hold_stays_a: assert property (hi_q > 4'h8 |=> sys_reset_out)
    else $error("hold released without power-on reset");
  init_guarded_a: assert property ($changed(init_done_protect_bit) |->
    $past(pready && pwrite) || $past(sys_reset_out) || sys_reset_out)
    else $error("init line changed without write");
endmodule

// *** sim/tb_supervision_timer.sv ***
/*
  self-checking bench for the supervision timer.
  assumes the checker is compiled first; dividers shortened to 4 and 8.
*/
`timescale 1ns/100ps
module tb_supervision_timer
  import wdt_pkg::*;
;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready, pslverr, init_done_protect_bit, nmi, sys_reset_out, irq, er;
  int          errors = 0;
  int          n_compared = 0;

  supervision_timer #(.DIV_F(4), .DIV_S(8)) i_supervision_timer
  (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .init_done_protect_bit(init_done_protect_bit),
    .nmi(nmi), .sys_reset_out(sys_reset_out), .irq(irq)
  );

  always #25 clk = ~clk;

  // ------
  // shared tasks
  // ------
  task automatic finish_test();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("apb answer", 1, n < 20);
    if (n >= 20)
      finish_test();
  endtask

  function automatic logic pick(input int k);
    return k == 0 ? nmi : sys_reset_out;
  endfunction

  // bounded wait; a hang here ends the run as a failure
  task automatic wait_lvl(input int k, input int lim);
    int n;
    n = 0;
    while (pick(k) !== 1'b1 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    chk("wait", 1, n < lim);
    if (n >= lim)
      finish_test();
  endtask

  task automatic pulse_len(input int e);
    int n;
    n = 0;
    // a prewarning on the slow divider lasts 256 ticks of 8 clocks
    wait_lvl(1, 2200);
    while (sys_reset_out === 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    chk("reset pulse", 32'(e), 32'(n));
  endtask

  // ------
  // scenarios
  // ------
  task automatic t_regs();
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 1, er);
    chk("unmapped data", 0, rd);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("state", ST_TIMEOUT, rd[21:16]);
    chk("count", 8'hff, rd[15:8]);
    apb(1'b0, ADDR_IRQ_MASK, 32'h0);
    chk("mask", IRQ_MASK_RST, rd);
  endtask

  task automatic t_overflow();
    apb(1'b1, ADDR_CTRL, 32'h50);
    apb(1'b1, ADDR_CTRL, 32'hfff000a1);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", 32'hfff00001, rd);
    chk("init line", 1, init_done_protect_bit);
    wait_lvl(0, 200);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("prewarn count", 12'hff0, rd[15:4]);
    chk("prewarn state", ST_PREWARN, rd[20:16]);
    chk("early reset", 0, sys_reset_out);
    pulse_len(8);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("record", 32'h21, rd[21:16]);
    chk("init cleared", 0, init_done_protect_bit);
  endtask

  task automatic t_disable();
    apb(1'b1, ADDR_CTRL, 32'h50);
    apb(1'b1, ADDR_CTRL, 32'h3ca7);
    repeat (40) @(posedge clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("stopped", 32'h20000, rd[21:0]);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h3c07, rd);
  endtask

  task automatic t_window();
    apb(1'b1, ADDR_IRQ_STAT, 32'hf);
    apb(1'b1, ADDR_IRQ_MASK, 32'hf);
    apb(1'b1, ADDR_CTRL, 32'h3c50);
    repeat (1000) @(posedge clk);
    chk("early nmi", 0, nmi);
    chk("irq idle", 0, irq);
    wait_lvl(0, 100);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk("irq status", 32'h9, rd);
    chk("irq", 1, irq);
    apb(1'b1, ADDR_IRQ_STAT, 32'h9);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk("irq cleared", 0, rd);
    chk("irq low", 0, irq);
    pulse_len(8);
  endtask

  task automatic t_hold();
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h30);
    wait_lvl(0, 10);
    chk("irq masked", 0, irq);
    pulse_len(40);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("hold state", ST_HOLD, rd[20:16]);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk("released", 0, {nmi, sys_reset_out});
  endtask

  task automatic t_guard();
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("record after por", 32'h01, rd[21:16]);
    apb(1'b1, ADDR_CTRL, 32'h50);
    chk("open no nmi", 0, nmi);
    apb(1'b1, ADDR_CTRL, 32'h51);
    wait_lvl(0, 10);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk("guard err status", 32'h9, rd);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("guard ctrl kept", 32'h0, rd);
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_overflow();
    t_disable();
    t_window();
    t_hold();
    t_guard();
    finish_test();
  end
endmodule

bind supervision_timer supervision_timer_checker #(.DIV_F(DIV_F), .DIV_S(DIV_S))
  i_supervision_timer_checker
(
  .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .init_done_protect_bit(init_done_protect_bit),
  .nmi(nmi), .sys_reset_out(sys_reset_out), .irq(irq)
);
